// ---- logic/lcx_decoder.sv ----
`timescale 1ns/1ps
module lcx_decoder
  import lcx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // byte link from the host, one byte per accepted cycle
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  output logic o_cmd_ready,
  output logic [7:0] o_status_byte,
  // function set state, valid in both sets, then basic-set row swaps and data order
  output logic o_sleep_bit,
  output logic o_ext_set,
  output logic o_vertical_addr,
  output logic o_column_mirror,
  output logic o_vertical_flip,
  output logic o_upper_row_swap,
  output logic o_lower_row_swap,
  output logic o_data_order,
  // basic-set configuration
  output logic o_voltage_range_select,
  output logic o_charge_pump_enable,
  // drive and scan settings
  output logic [1:0] o_display_mode,
  output logic [1:0] o_temp_coeff_select,
  output logic [1:0] o_charge_pump_stages,
  output logic [2:0] o_bias_select,
  output logic o_full_row_drive,
  output logic [7:0] o_partial_row_mask,
  output logic [6:0] o_initial_row,
  output logic [6:0] o_start_line,
  output logic [6:0] o_drive_voltage_code,
  output logic [6:0] o_column_wrap_limit,
  output logic [3:0] o_bank_wrap_limit,
  output logic [6:0] o_data_length,
  // sticky flags for the programming path
  output logic o_calibration_mode,
  output logic o_otp_disabled,
  // one-cycle strobes towards the address counter
  output logic o_set_y_pulse,
  output logic [3:0] o_set_y_value,
  output logic o_set_x_pulse,
  output logic [6:0] o_set_x_value
);
  import lcx_pkg::*;

  // ********************************************************
  // decode helpers
  // ********************************************************
  function automatic logic [6:0] clamp_row(input logic [6:0] v);
    clamp_row = (v > ROW_LIMIT) ? ROW_LIMIT : v;
  endfunction

  // a byte decodes as a command only when no operand is owed
  function automatic logic cmd_slot(input lcx_operand_type p, input lcx_basic_op_type q);
    cmd_slot = (p == OP_NONE) && (q == OP2_NONE);
  endfunction

  // handshake and sequencer hooks
  logic take;
  logic soft_busy;
  logic soft_clear;
  logic wipe;
  logic [7:0] b;
  logic is_cmd;
  // operand owed by a double command
  lcx_operand_type pend_q;
  lcx_basic_op_type bpend_q;
  // configuration registers, one per field
  logic ext_q;
  logic sleep_q;
  logic vaddr_q;
  logic mx_q;
  logic my_q;
  logic trs_q;
  logic brs_q;
  logic dord_q;
  logic prs_q;
  logic pc_q;
  logic [1:0] disp_q;
  logic [1:0] tc_q;
  logic [1:0] pump_q;
  logic [2:0] bias_q;
  logic full_q;
  logic [7:0] mask_q;
  logic [6:0] row_q;
  logic [6:0] line_q;
  logic [6:0] volt_q;
  logic [6:0] xmax_q;
  logic [3:0] ymax_q;
  logic [6:0] dlen_q;
  logic calib_q;
  logic otp_off_q;
  // address strobes and their values
  logic y_pulse_q;
  logic [3:0] y_val_q;
  logic x_pulse_q;
  logic [6:0] x_val_q;

  // a byte is taken only while no reset sequence runs
  assign b = i_cmd_byte;
  assign take = i_cmd_valid && !soft_busy;
  // soft reset reuses the hard reset path one cycle after the command
  assign wipe = !i_rst_n || soft_clear;
  assign is_cmd = cmd_slot(pend_q, bpend_q);

  // ********************************************************
  // software reset sequencer
  // ********************************************************
  lcx_reset_seq #(
    .CYCLES(SOFT_RESET_CYCLES)
  ) u_reset_seq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(take && is_cmd && b == CMD_SOFT_RESET),
    .o_busy(soft_busy),
    .o_clear(soft_clear)
  );

  // commands refused while the reset sequence runs
  assign o_cmd_ready = !soft_busy;

  // ********************************************************
  // operand tracking for double commands
  // ********************************************************
  // the byte after a first half is never decoded as a command
  // reserved doubles still pend, so their operand is swallowed
  always_ff @(posedge i_clk) begin
    if (wipe) begin
      pend_q <= OP_NONE;
      bpend_q <= OP2_NONE;
    end else if (take) begin
      pend_q <= OP_NONE;
      bpend_q <= OP2_NONE;
      if (is_cmd) begin
        if (ext_q) begin
          case (b[7:3])
            CMD_DRIVE_MODE: pend_q <= OP_DRIVE;
            CMD_ROW_MASK: pend_q <= OP_MASK;
            CMD_INIT_ROW: pend_q <= OP_ROW;
            CMD_START_LINE: pend_q <= OP_LINE;
            CMD_RSVD_DBL: pend_q <= OP_RSVD; // operand swallowed
            default: pend_q <= OP_NONE;
          endcase
        end else begin
          if (b[7:4] == CMD_XMAX) pend_q <= OP_XMAX;
          if (b[7:4] == CMD_YMAX) pend_q <= OP_YMAX;
          if (b[7:1] == CMD_DISP_CFG) bpend_q <= OP2_CFG;
          if (b[7:4] == CMD_DATA_LEN && b != CMD_SOFT_RESET) bpend_q <= OP2_LEN;
        end
      end
    end
  end

  // ********************************************************
  // function set: valid in both sets
  // ********************************************************
  always_ff @(posedge i_clk) begin
    if (wipe) begin
      ext_q <= 1'b0;
      sleep_q <= 1'b1;
      vaddr_q <= 1'b0;
      mx_q <= 1'b0;
      my_q <= 1'b0;
    end else if (take && is_cmd && b[7:5] == CMD_FUNC_SET) begin
      mx_q <= b[4];
      my_q <= b[3];
      sleep_q <= b[2];
      vaddr_q <= b[1];
      ext_q <= b[0];
    end
  end

  // ********************************************************
  // extended-set single commands
  // ********************************************************
  // reserved single codes fall through the chain unchanged
  // at most one pattern matches a byte, so the chain order is free
  always_ff @(posedge i_clk) begin
    if (wipe) begin
      pump_q <= RST_PUMP;
      bias_q <= RST_BIAS;
      volt_q <= RST_VOLT;
      tc_q <= RST_TC;
      calib_q <= 1'b0;
      otp_off_q <= 1'b0;
    end else if (take && ext_q && is_cmd) begin
      if (b[7]) begin
        volt_q <= b[6:0];
      end else if (b[7:2] == CMD_PUMP_STAGES) begin
        pump_q <= b[1:0];
      end else if (b[7:2] == CMD_TEMP) begin
        tc_q <= b[1:0];
      end else if (b[7:3] == CMD_BIAS) begin
        bias_q <= b[2:0];
      end else if (b == CMD_CALIB) begin
        calib_q <= 1'b1;
      end else if (b == CMD_OTP_OFF) begin
        otp_off_q <= 1'b1;
      end
    end
  end

  // ********************************************************
  // extended-set operands
  // ********************************************************
  // out-of-range rows are clamped to 66, line 67 holds icons
  // pend_q names the extended operands only in the extended set, so no set test here
  always_ff @(posedge i_clk) begin
    if (wipe) begin
      full_q <= 1'b1;
      mask_q <= RST_MASK;
      row_q <= RST_ROW;
      line_q <= RST_ROW;
    end else if (take) begin
      case (pend_q)
        OP_DRIVE: full_q <= b[0];
        OP_MASK: mask_q <= b;
        OP_ROW: row_q <= clamp_row(b[6:0]);
        OP_LINE: line_q <= clamp_row(b[6:0]);
        default: ;
      endcase
    end
  end

  // ********************************************************
  // basic-set commands
  // ********************************************************
  always_ff @(posedge i_clk) begin
    if (wipe) begin
      disp_q <= RST_DISP;
      prs_q <= 1'b0;
      pc_q <= 1'b1;
      trs_q <= 1'b0;
      brs_q <= 1'b0;
      dord_q <= 1'b0;
      xmax_q <= RST_XMAX;
      ymax_q <= RST_YMAX;
      dlen_q <= '0;
    end else if (take && !ext_q) begin
      // basic decode sleeps while the extended set is on
      if (is_cmd) begin
        if (b[7:3] == CMD_DISP_CTRL && !b[1]) disp_q <= {b[2], b[0]};
        if (b[7:1] == CMD_RANGE) prs_q <= b[0];
        if (b[7:1] == CMD_PUMP_ON) pc_q <= b[0];
      end
      case (pend_q)
        OP_XMAX: xmax_q <= (b[6:0] > XMAX_LIMIT) ? XMAX_LIMIT : b[6:0];
        OP_YMAX: ymax_q <= (b[3:0] > YMAX_LIMIT) ? YMAX_LIMIT : b[3:0];
        default: ;
      endcase
      case (bpend_q)
        OP2_CFG: begin
          dord_q <= b[2];
          trs_q <= b[1];
          brs_q <= b[0];
        end
        OP2_LEN: dlen_q <= b[6:0];
        default: ;
      endcase
    end
  end

  // address set strobes go to the address counter for one cycle
  always_ff @(posedge i_clk) begin
    if (wipe) begin
      y_pulse_q <= 1'b0;
      x_pulse_q <= 1'b0;
      y_val_q <= '0;
      x_val_q <= '0;
    end else begin
      // values follow every taken byte; only the strobe qualifies them
      y_pulse_q <= take && !ext_q && is_cmd && b[7:4] == CMD_SET_Y;
      x_pulse_q <= take && !ext_q && is_cmd && b[7];
      if (take) y_val_q <= b[3:0];
      if (take) x_val_q <= b[6:0];
    end
  end

  // ********************************************************
  // status byte and outputs
  // ********************************************************
  // display counts as on when awake and not blanked
  assign o_status_byte = {soft_busy,
                          !sleep_q && disp_q != DISP_BLANK,
                          soft_busy,
                          MAKER_CODE, CLASS_CODE};

  // plain taps of the registers above
  assign o_sleep_bit = sleep_q;
  assign o_ext_set = ext_q;
  assign o_vertical_addr = vaddr_q;
  assign o_column_mirror = mx_q;
  assign o_vertical_flip = my_q;
  assign o_upper_row_swap = trs_q;
  assign o_lower_row_swap = brs_q;
  assign o_data_order = dord_q;
  assign o_voltage_range_select = prs_q;
  assign o_charge_pump_enable = pc_q;
  assign o_display_mode = disp_q;
  assign o_temp_coeff_select = tc_q;
  assign o_charge_pump_stages = pump_q;
  assign o_bias_select = bias_q;
  assign o_full_row_drive = full_q;
  assign o_partial_row_mask = mask_q;
  assign o_initial_row = row_q;
  assign o_start_line = line_q;
  assign o_drive_voltage_code = volt_q;
  assign o_column_wrap_limit = xmax_q;
  assign o_bank_wrap_limit = ymax_q;
  assign o_data_length = dlen_q;
  assign o_calibration_mode = calib_q;
  assign o_otp_disabled = otp_off_q;
  assign o_set_y_pulse = y_pulse_q;
  assign o_set_y_value = y_val_q;
  assign o_set_x_pulse = x_pulse_q;
  assign o_set_x_value = x_val_q;
endmodule

// ---- logic/lcx_pkg.sv ----
package lcx_pkg;
  // ********************************************************
  // command byte patterns
  // ********************************************************
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [2:0] CMD_FUNC_SET = 3'h1;        // 001 mx my pd v h
  localparam logic [4:0] CMD_STATUS_RD = 5'h03;       // 00011 0xx (read side)
  // basic set
  localparam logic [4:0] CMD_DISP_CTRL = 5'h01;      // 00001 d 0 e
  localparam logic [6:0] CMD_RANGE = 7'h08;          // 0001000 prs
  localparam logic [6:0] CMD_PUMP_ON = 7'h09;        // 000100 1 pc
  localparam logic [6:0] CMD_DISP_CFG = 7'h0B;       // 000101 1 x, double
  localparam logic [3:0] CMD_DATA_LEN = 4'h7;        // 0111xxxx, double
  localparam logic [3:0] CMD_SET_Y = 4'h4;           // 0100yyyy
  localparam logic [3:0] CMD_YMAX = 4'h5;            // 0101xxxx, double
  localparam logic [3:0] CMD_XMAX = 4'h6;            // 0110xxxx, double
  // extended set
  localparam logic [5:0] CMD_TEMP = 6'h01;           // 000001 tc
  localparam logic [5:0] CMD_PUMP_STAGES = 6'h02;    // 000010 s
  localparam logic [4:0] CMD_BIAS = 5'h02;           // 00010 bs
  localparam logic [4:0] CMD_RSVD_DBL = 5'h0C;       // 01100xxx, double
  localparam logic [4:0] CMD_DRIVE_MODE = 5'h0A;     // 01010xxx, double
  localparam logic [4:0] CMD_ROW_MASK = 5'h0D;       // 01101xxx, double
  localparam logic [4:0] CMD_INIT_ROW = 5'h09;       // 01001xxx, double
  localparam logic [4:0] CMD_START_LINE = 5'h0B;     // 01011xxx, double
  localparam logic [7:0] CMD_OTP_OFF = 8'h1C;
  localparam logic [7:0] CMD_CALIB = 8'h1E;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h71;
  // ********************************************************
  // reset values and limits
  // ********************************************************
  localparam logic [1:0] RST_PUMP = 2'h0;
  localparam logic [2:0] RST_BIAS = 3'h0;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [6:0] RST_ROW = 7'h00;
  localparam logic [6:0] RST_VOLT = 7'h00;
  localparam logic [6:0] RST_XMAX = 7'h65;
  localparam logic [3:0] RST_YMAX = 4'h8;
  localparam logic [1:0] RST_DISP = 2'h0;
  localparam logic [1:0] RST_TC = 2'h0;
  localparam logic [6:0] ROW_LIMIT = 7'h42;          // highest row or line, 66
  localparam logic [6:0] XMAX_LIMIT = 7'h65;
  localparam logic [3:0] YMAX_LIMIT = 4'h8;
  localparam logic [2:0] MAKER_CODE = 3'h5;          // arbitrary value
  localparam logic [1:0] CLASS_CODE = 2'h2;          // arbitrary value
  localparam int SOFT_RESET_CYCLES = 8;              // reset sequence length
  // display mode {d, e}
  localparam logic [1:0] DISP_BLANK = 2'h0;
  localparam logic [1:0] DISP_ALL_ON = 2'h1;
  localparam logic [1:0] DISP_NORMAL = 2'h2;
  localparam logic [1:0] DISP_INVERSE = 2'h3;
  // second byte expected
  typedef enum logic [2:0] {
    OP_NONE, OP_DRIVE, OP_MASK, OP_ROW, OP_LINE, OP_RSVD, OP_XMAX, OP_YMAX
  } lcx_operand_type;
  typedef enum logic [1:0] {
    OP2_NONE, OP2_CFG, OP2_LEN
  } lcx_basic_op_type;
endpackage

// ---- logic/lcx_reset_seq.sv ----
`timescale 1ns/1ps
// ********************************************************
// software reset sequencer
// ********************************************************
module lcx_reset_seq #(
  parameter int CYCLES = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  output logic o_busy,
  output logic o_clear
);
  logic [$clog2(CYCLES+1)-1:0] cnt_q;

  // counts down; clear pulses when the count leaves zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_start && cnt_q == '0) begin
      cnt_q <= ($clog2(CYCLES+1))'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_busy = (cnt_q != '0);
  assign o_clear = (cnt_q == ($clog2(CYCLES+1))'(CYCLES));
endmodule

// ---- testbench/lcx_decoder_tb.sv ----
`timescale 1ns/1ps
// ****************
// decoder bench
// ****************
module lcx_decoder_tb;
  import lcx_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cmd_valid, o_cmd_ready, o_sleep_bit, o_ext_set, o_column_mirror, o_vertical_flip;
  logic o_upper_row_swap, o_lower_row_swap, o_voltage_range_select, o_full_row_drive;
  logic o_calibration_mode, o_otp_disabled;
  logic o_vertical_addr, o_data_order, o_charge_pump_enable, o_set_y_pulse, o_set_x_pulse;
  logic [1:0] o_display_mode, o_temp_coeff_select, o_charge_pump_stages;
  logic [2:0] o_bias_select;
  logic [3:0] o_bank_wrap_limit, o_set_y_value;
  logic [6:0] o_data_length, o_set_x_value;
  logic [6:0] o_initial_row, o_start_line, o_drive_voltage_code, o_column_wrap_limit;
  logic [7:0] i_cmd_byte, o_status_byte, o_partial_row_mask;
  int err_count = 0;
  int checks_done = 0;
  always #20 i_clk = ~i_clk;
  lcx_host_model h (.i_clk, .i_ready(o_cmd_ready), .o_valid(i_cmd_valid), .o_byte(i_cmd_byte));
  lcx_decoder DUT (.i_clk, .i_rst_n, .i_cmd_valid, .i_cmd_byte, .o_cmd_ready, .o_status_byte,
    .o_sleep_bit, .o_ext_set, .o_vertical_addr, .o_column_mirror, .o_vertical_flip,
    .o_upper_row_swap, .o_lower_row_swap, .o_data_order, .o_voltage_range_select,
    .o_charge_pump_enable, .o_display_mode, .o_temp_coeff_select, .o_charge_pump_stages,
    .o_bias_select, .o_full_row_drive, .o_partial_row_mask, .o_initial_row, .o_start_line,
    .o_drive_voltage_code, .o_column_wrap_limit, .o_bank_wrap_limit, .o_data_length,
    .o_calibration_mode, .o_otp_disabled, .o_set_y_pulse, .o_set_y_value,
    .o_set_x_pulse, .o_set_x_value);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one command, then release, so checks see the settled result
  task automatic put(input logic [7:0] b);
    h.send(b);
    h.idle();
  endtask
  function automatic logic [7:0] clamp(input logic [7:0] v);
    return (v > 8'h42) ? 8'h42 : v;
  endfunction
  // power-up values, shared by hard and soft reset
  task automatic chk_reset();
    chk("status", o_status_byte, 8'h16);
    chk("sleep", {6'h0, o_vertical_addr, o_sleep_bit}, 8'h01);
    chk("mirror", {6'h0, o_column_mirror, o_vertical_flip}, 8'h00);
    chk("swap", {5'h0, o_data_order, o_upper_row_swap, o_lower_row_swap}, 8'h00);
    chk("range", {6'h0, o_charge_pump_enable, o_voltage_range_select}, 8'h02);
    chk("xmax", {1'b0, o_column_wrap_limit}, 8'h65);
    chk("ymax", {4'h0, o_bank_wrap_limit}, 8'h08);
    chk("disp", {6'h0, o_display_mode}, 8'h00);
    chk("tc", {6'h0, o_temp_coeff_select}, 8'h00);
    chk("pump", {6'h0, o_charge_pump_stages}, 8'h00);
    chk("bias", {5'h0, o_bias_select}, 8'h00);
    chk("full", {7'h0, o_full_row_drive}, 8'h01);
    chk("mask", o_partial_row_mask, 8'hFF);
    chk("rows", {1'b0, o_initial_row | o_start_line}, 8'h00);
    chk("vpr", {1'b0, o_drive_voltage_code}, 8'h00);
    chk("dlen", {1'b0, o_data_length}, 8'h00);
    chk("strobe", {6'h0, o_set_x_pulse, o_set_y_pulse}, 8'h00);
  endtask
  // fixed 5000-cycle limit, far above the test length; a hang ends here
  initial begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    logic [7:0] r;
    int n;
    r = 8'($urandom(32'hFFD9));
    repeat (8) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk_reset();
    // basic set: mirrors, display modes, range, swap
    put(8'h3A);
    chk("mirror", {6'h0, o_column_mirror, o_vertical_flip}, 8'h03);
    chk("fset", {6'h0, o_vertical_addr, o_sleep_bit}, 8'h02);
    for (int m = 0; m < 4; m++) begin
      put(8'h08 | {5'h0, m[1], 1'b0, m[0]});
      chk("disp", {6'h0, o_display_mode}, 8'(m));
      chk("on", {7'h0, o_status_byte[6]}, {7'h0, m != 0});
    end
    put(8'h11);
    put(8'h12);
    chk("range", {6'h0, o_charge_pump_enable, o_voltage_range_select}, 8'h01);
    put(8'h16);
    put(8'h07);
    chk("swap", {5'h0, o_data_order, o_upper_row_swap, o_lower_row_swap}, 8'h07);
    // wrap limits load in range and clamp above it
    put(8'h6F);
    put(8'h2A);
    chk("xmax", {1'b0, o_column_wrap_limit}, 8'h2A);
    put(8'h60);
    put(8'h7F);
    chk("xmax", {1'b0, o_column_wrap_limit}, 8'h65);
    put(8'h50);
    put(8'h03);
    chk("ymax", {4'h0, o_bank_wrap_limit}, 8'h03);
    put(8'h5A);
    put(8'h0C);
    chk("ymax", {4'h0, o_bank_wrap_limit}, 8'h08);
    put(8'h7E);
    put(8'h2A);
    chk("dlen", {1'b0, o_data_length}, 8'h2A);
    // extended codes sent in basic set must not act
    put(8'h0B);
    put(8'h85);
    chk("gate", {1'b0, o_drive_voltage_code} | {6'h0, o_charge_pump_stages}, 8'h00);
    chk("setx", {o_set_x_pulse, o_set_x_value}, 8'h85);
    put(8'h43);
    chk("sety", {2'h0, o_set_x_pulse, o_set_y_pulse, o_set_y_value}, 8'h13);
    put(8'h21);
    chk("ext", {7'h0, o_ext_set}, 8'h01);
    for (int s = 0; s < 4; s++) begin
      put(8'h08 | 8'(s));
      chk("pump", {6'h0, o_charge_pump_stages}, 8'(s));
      put(8'h04 | 8'(s));
      chk("tc", {6'h0, o_temp_coeff_select}, 8'(s));
    end
    for (int i = 0; i < 10; i++) begin
      r = 8'($urandom());
      if (i < 2) r[6:0] = 7'h42 + 7'(i);
      put(8'h10 | {5'h0, r[2:0]});
      chk("bias", {5'h0, o_bias_select}, {5'h0, r[2:0]});
      put(8'h80 | r);
      chk("vpr", {1'b0, o_drive_voltage_code}, {1'b0, r[6:0]});
      put(8'h68);
      put(r | 8'h80);
      chk("mask", o_partial_row_mask, r | 8'h80);
      // back to back: operand follows its first byte without a gap
      h.send(8'h48);
      h.send({1'b0, r[6:0]});
      h.send(8'h58);
      h.send({1'b0, ~r[6:0]});
      h.idle();
      chk("row", {1'b0, o_initial_row}, clamp({1'b0, r[6:0]}));
      chk("line", {1'b0, o_start_line}, clamp({1'b0, ~r[6:0]}));
      put(8'h50);
      put({7'h0, r[0]});
      chk("full", {7'h0, o_full_row_drive}, {7'h0, r[0]});
    end
    put(8'h1C);
    chk("otp", {7'h0, o_otp_disabled}, 8'h01);
    put(8'h1E);
    chk("cal", {7'h0, o_calibration_mode}, 8'h01);
    put(8'h71);
    chk("busy", {5'h0, o_status_byte[7], o_status_byte[5], o_cmd_ready}, 8'h06);
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk("rst_len", 8'(n), 8'h08);
    chk_reset();
    chk("ext", {7'h0, o_ext_set}, 8'h00);
    report_and_stop();
  end
endmodule
bind lcx_decoder lcx_props u_props (.*);

// ---- testbench/lcx_host_model.sv ----
`timescale 1ns/1ps
// ****************
// host side model
// ****************
module lcx_host_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_byte
);
  initial begin
    o_valid = 1'b0;
    o_byte = 8'h00;
  end
  // offer at the falling edge, hold until the rising edge that takes it
  task automatic send(input logic [7:0] b); // any byte, sent as given
    int n;
    @(negedge i_clk);
    o_valid = 1'b1;
    o_byte = b;
    n = 0;
    while (i_ready !== 1'b1 && n < 64) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
  endtask
  // released data inverts so a stale byte never looks valid
  task automatic idle();
    @(negedge i_clk);
    o_valid = 1'b0;
    o_byte = ~o_byte;
  endtask
endmodule

// ---- testbench/lcx_props.sv ----
`timescale 1ns/1ps
// ****************
// decoder checker
// ****************
module lcx_props (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic o_cmd_ready,
  input wire logic [7:0] o_status_byte,
  input wire logic o_sleep_bit,
  input wire logic o_ext_set,
  input wire logic [1:0] o_display_mode,
  input wire logic [1:0] o_charge_pump_stages,
  input wire logic [2:0] o_bias_select,
  input wire logic [7:0] o_partial_row_mask,
  input wire logic [6:0] o_initial_row,
  input wire logic [6:0] o_drive_voltage_code
);
  logic take, cmd, dbl, op_q;
  logic [7:0] b, first_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // operands are tracked so that they are never read as commands
  assign b = i_cmd_byte;
  assign take = i_cmd_valid && o_cmd_ready;
  assign cmd = take && !op_q;
  assign dbl = o_ext_set ? (b[7:3] inside {5'h0A, 5'h0D, 5'h09, 5'h0B, 5'h0C}) :
    (b[7:4] inside {4'h5, 4'h6} || b[7:1] == 7'h0B || (b[7:4] == 4'h7 && b != 8'h71));
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) op_q <= 1'b0;
    else if (take) op_q <= cmd && dbl;
  end
  // first byte kept for pairing with its operand
  always_ff @(posedge i_clk) begin
    if (take) first_q <= b;
  end
  pump_stage_a: assert property (
    cmd && o_ext_set && b[7:2] == 6'h02 |=> o_charge_pump_stages == $past(b[1:0]))
    else $error("pump stages not loaded");
  bias_load_a: assert property (
    cmd && o_ext_set && b[7:3] == 5'h02 |=> o_bias_select == $past(b[2:0]))
    else $error("bias not loaded");
  volt_code_a: assert property (
    cmd && o_ext_set && b[7] |=> o_drive_voltage_code == $past(b[6:0]))
    else $error("drive voltage code not loaded");
  row_mask_a: assert property (
    take && op_q && o_ext_set && first_q[7:3] == 5'h0D |=> o_partial_row_mask == $past(b))
    else $error("row mask not loaded from operand");
  init_row_a: assert property (
    take && op_q && o_ext_set && first_q[7:3] == 5'h09 |=>
    o_initial_row == ($past(b[6:0]) > 7'h42 ? 7'h42 : $past(b[6:0])))
    else $error("initial row wrong");
  soft_reset_a: assert property (
    cmd && b == 8'h71 |=> (o_status_byte[5])[*8] ##1 !o_status_byte[5])
    else $error("reset flag length wrong");
  reset_state_a: assert property (
    cmd && b == 8'h71 |-> ##2 o_sleep_bit && !o_ext_set && o_partial_row_mask == 8'hFF)
    else $error("soft reset left state");
  busy_flag_a: assert property (o_status_byte[7] == !o_cmd_ready)
    else $error("busy flag disagrees with ready");
  status_fixed_a: assert property (o_status_byte[4:0] == 5'h16)
    else $error("fixed status codes wrong");
  display_on_a: assert property (
    o_status_byte[6] == (!o_sleep_bit && o_display_mode != 2'h0))
    else $error("display on flag wrong");
  cover property (cmd && b == 8'h71);
  cover property (take && op_q);
  cover property (cmd && o_ext_set && b[7]);
endmodule
